// File: rtl/twtb_pkg.sv
package twtb_pkg;

   localparam int TWTB_BYTE_BITS = 8;
   localparam int TWTB_FIFO_DEPTH = 8;
   localparam logic [3:0] TWTB_TYPE_MEM = 4'h_a;
   localparam logic [3:0] TWTB_TYPE_PAGE = 4'h_6;
   localparam logic [3:0] TWTB_TYPE_TEMP = 4'h_3;
   localparam logic [3:0] TWTB_BIT_LAST = 4'h_7;
   localparam logic [3:0] TWTB_BIT_ACK = 4'h_8;
   localparam logic [7:0] TWTB_TX_RESET = 8'h_ff;
   localparam logic [1:0] TWTB_ALERT_INTR = 2'h_0;
   localparam logic [1:0] TWTB_ALERT_COMP = 2'h_1;
   localparam logic [1:0] TWTB_ALERT_CRIT = 2'h_2;

   typedef struct packed {
      logic [7:0] data;
      logic first;
   } twtb_rx_type;

   typedef enum {
      TWTB_IDLE,
      TWTB_ADDR,
      TWTB_ADDR_ACK,
      TWTB_RX,
      TWTB_RX_ACK,
      TWTB_TX,
      TWTB_TX_ACK,
      TWTB_STANDBY
   } twtb_state_type;

endpackage

// File: rtl/twtb_fifo.sv
`timescale 1ns/1ps
module twtb_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rd_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_r[wr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// File: rtl/twtb_target.sv
`timescale 1ns/1ps
// Contract
// - Capture received bits on serial clock rising edges.
// - Change driven data only on serial clock falling edges; a Start or Stop also releases the data line at once.
// - Data line is open drain: pull low or release only.
// - Open-drain alert output with interrupt, comparator, critical modes.
// - Three strap inputs form the low three address bits.
// - Bytes travel most significant bit first.
// - Nine clocks per byte; receiver answers in the ninth.
// - Data changes only while clock low, stable while high.
// - Start is data falling while clock high.
// - Stop is data rising while clock high; return to idle.
// - Ignore all activity until a Start is seen.
// - Repeated Start ends transfer and starts a new operation.
// - No limit on bytes between Start and Stop.
// - Bus idle only when both lines are high.
// - After received byte, hold data low for whole ninth clock; the data line is left released when the receive queue is full.
// - Master no-acknowledge on read makes device release data line.
// - Address mismatch gives no-acknowledge and standby.
module twtb_target
   import twtb_pkg::*;
#(
   parameter int FIFO_DEPTH = TWTB_FIFO_DEPTH
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_strap_bit2_i,
   input wire logic addr_strap_bit1_i,
   input wire logic addr_strap_bit0_i,
   input wire logic alert_req_i,
   input wire logic alert_crit_i,
   input wire logic [1:0] alert_mode_i,
   input wire logic alert_clear_i,
   output logic alert_o,
   output logic alert_oe_o,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_first_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [3:0] sel_type_o,
   output logic sel_read_o,
   output logic busy_o,
   output logic bus_idle_o,
   output logic start_o,
   output logic stop_o
);
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic scl_d_r;
   logic sda_d_r;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   twtb_state_type state_r;
   logic [3:0] bit_r;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic match;
   logic first_r;
   logic pull_r;
   logic alert_r;
   logic push_r;
   twtb_rx_type push_data_r;
   twtb_rx_type out_word;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [2:0] strap_meta_r;
   logic [2:0] strap_r;

   // Each pin passes two flip-flops; the second stage and a one-cycle delayed copy of it are read.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         scl_sync_r <= 2'h_3;
         sda_sync_r <= 2'h_3;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_i};
         sda_sync_r <= {sda_sync_r[0], sda_i};
         scl_d_r <= scl_sync_r[1];
         sda_d_r <= sda_sync_r[1];
      end
   end

   assign scl_rise = scl_sync_r[1] && !scl_d_r;
   assign scl_fall = !scl_sync_r[1] && scl_d_r;
   assign start_ev = scl_sync_r[1] && scl_d_r &&
      sda_d_r && !sda_sync_r[1];
   assign stop_ev = scl_sync_r[1] && scl_d_r &&
      !sda_d_r && sda_sync_r[1];

   // Straps are pins, so they pass two flip-flops like the bus lines.
   always_ff @(posedge clock_i) begin
      strap_meta_r <= {addr_strap_bit2_i, addr_strap_bit1_i,
         addr_strap_bit0_i};
      strap_r <= strap_meta_r;
   end

   assign match = (shift_r[7:4] == TWTB_TYPE_MEM ||
      shift_r[7:4] == TWTB_TYPE_PAGE || shift_r[7:4] == TWTB_TYPE_TEMP) &&
      (shift_r[3:1] == strap_r);

   // Bit engine; a Start or Stop overrides any point of a byte.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_r <= TWTB_IDLE;
         bit_r <= '0;
         shift_r <= '0;
         first_r <= 1'b0;
         sel_type_o <= '0;
         sel_read_o <= 1'b0;
      end else if (start_ev) begin
         state_r <= TWTB_ADDR;
         bit_r <= '0;
      end else if (stop_ev) begin
         state_r <= TWTB_IDLE;
         bit_r <= '0;
      end else if (scl_rise) begin
         case (state_r)
            TWTB_ADDR, TWTB_RX: begin
               shift_r <= {shift_r[6:0], sda_sync_r[1]};
               bit_r <= bit_r + 1'b1;
            end
            TWTB_TX: begin
               bit_r <= bit_r + 1'b1;
            end
            TWTB_TX_ACK: begin
               // Master answer is latched here; high means done.
               shift_r <= {7'h_00, sda_sync_r[1]};
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_r)
            TWTB_ADDR: begin
               if (bit_r == TWTB_BIT_ACK) begin
                  if (match) begin
                     state_r <= TWTB_ADDR_ACK;
                     sel_type_o <= shift_r[7:4];
                     sel_read_o <= shift_r[0];
                     first_r <= 1'b1;
                  end else begin
                     state_r <= TWTB_STANDBY;
                  end
               end
            end
            TWTB_RX: begin
               if (bit_r == TWTB_BIT_ACK) begin
                  state_r <= TWTB_RX_ACK;
               end
            end
            TWTB_ADDR_ACK, TWTB_RX_ACK: begin
               bit_r <= '0;
               first_r <= (state_r == TWTB_ADDR_ACK);
               state_r <= sel_read_o ? TWTB_TX : TWTB_RX;
            end
            TWTB_TX: begin
               if (bit_r == TWTB_BIT_ACK) begin
                  state_r <= TWTB_TX_ACK;
               end
            end
            TWTB_TX_ACK: begin
               bit_r <= '0;
               state_r <= shift_r[0] ? TWTB_STANDBY : TWTB_TX;
            end
            default: begin
            end
         endcase
      end
   end

   // Received bytes are queued; the first one after the address is marked.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         push_r <= 1'b0;
         push_data_r <= '0;
      end else begin
         if (push_r && fifo_in_ready) begin
            push_r <= 1'b0;
         end
         // A byte refused for a full queue is dropped, never queued later.
         if (scl_fall && !start_ev && !stop_ev && state_r == TWTB_RX &&
             bit_r == TWTB_BIT_ACK && fifo_in_ready) begin
            push_r <= 1'b1;
            push_data_r <= '{data: shift_r, first: first_r};
         end
      end
   end

   // Transmit byte loads at the start of each read byte.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         tx_r <= TWTB_TX_RESET;
         tx_ready_o <= 1'b0;
      end else begin
         tx_ready_o <= 1'b0;
         if (scl_fall && !start_ev && !stop_ev &&
             ((state_r == TWTB_ADDR_ACK && sel_read_o) ||
              (state_r == TWTB_TX_ACK && !shift_r[0]))) begin
            tx_r <= tx_valid_i ? tx_data_i : TWTB_TX_RESET;
            tx_ready_o <= 1'b1;
         end else if (scl_fall && state_r == TWTB_TX) begin
            tx_r <= {tx_r[6:0], 1'b1};
         end
      end
   end

   // The data pin is only pulled low or released; it changes at a fall, or is released at a Start or Stop.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pull_r <= 1'b0;
      end else if (start_ev || stop_ev) begin
         pull_r <= 1'b0;
      end else if (scl_fall) begin
         case (state_r)
            TWTB_ADDR: begin
               pull_r <= (bit_r == TWTB_BIT_ACK) && match;
            end
            TWTB_RX: begin
               pull_r <= (bit_r == TWTB_BIT_ACK) && fifo_in_ready;
            end
            TWTB_ADDR_ACK, TWTB_RX_ACK: begin
               pull_r <= sel_read_o &&
                  !((tx_valid_i ? tx_data_i[7] : 1'b1));
            end
            TWTB_TX: begin
               pull_r <= (bit_r != TWTB_BIT_ACK) && !tx_r[6];
            end
            TWTB_TX_ACK: begin
               pull_r <= !shift_r[0] &&
                  !((tx_valid_i ? tx_data_i[7] : 1'b1));
            end
            default: begin
               pull_r <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         sda_oe_o <= pull_r;
      end
   end

   // Alert: comparator follows its cause, interrupt holds until cleared.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         alert_r <= 1'b0;
      end else begin
         case (alert_mode_i)
            TWTB_ALERT_COMP: begin
               alert_r <= alert_req_i;
            end
            TWTB_ALERT_CRIT: begin
               alert_r <= alert_crit_i;
            end
            TWTB_ALERT_INTR: begin
               if (alert_req_i) begin
                  alert_r <= 1'b1;
               end else if (alert_clear_i) begin
                  alert_r <= 1'b0;
               end
            end
            default: begin
               alert_r <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         alert_o <= 1'b0;
         alert_oe_o <= 1'b0;
         busy_o <= 1'b0;
         bus_idle_o <= 1'b1;
         start_o <= 1'b0;
         stop_o <= 1'b0;
         rx_data_o <= '0;
         rx_first_o <= 1'b0;
         rx_valid_o <= 1'b0;
      end else begin
         alert_o <= 1'b0;
         alert_oe_o <= alert_r;
         busy_o <= (state_r != TWTB_IDLE) && (state_r != TWTB_STANDBY);
         bus_idle_o <= scl_sync_r[1] && sda_sync_r[1];
         start_o <= start_ev;
         stop_o <= stop_ev;
         if (!rx_valid_o || rx_ready_i) begin
            rx_valid_o <= fifo_out_valid;
            rx_data_o <= out_word.data;
            rx_first_o <= out_word.first;
         end
      end
   end

   twtb_fifo #(
      .WIDTH($bits(twtb_rx_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .in_data_i(push_data_r),
      .in_valid_i(push_r),
      .in_ready_o(fifo_in_ready),
      .out_data_o(out_word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(!rx_valid_o || rx_ready_i)
   );
endmodule

// File: tb/twtb_target_asserts.sv
`timescale 1ns/1ps
module twtb_target_asserts
   import twtb_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic alert_req_i,
   input wire logic [1:0] alert_mode_i,
   input wire logic alert_oe_o,
   input wire logic [7:0] rx_data_o,
   input wire logic rx_valid_o,
   input wire logic rx_ready_i,
   input wire logic busy_o,
   input wire logic bus_idle_o,
   input wire logic start_o,
   input wire logic stop_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_start;
      scl_i && $fell(sda_i);
   endsequence
   sequence s_stop;
      scl_i && $rose(sda_i);
   endsequence
   sequence s_high_drive;
      scl_i && sda_oe_o ##1 scl_i;
   endsequence
   AST_SDA_OPEN_DRAIN: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   AST_IDLE_SEEN: assert property ((scl_i && sda_i)[*5] |-> bus_idle_o)
      else $error("idle bus not flagged");
   AST_DRIVE_IN_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
      else $error("data pulled while clock high");
   AST_ACK_HOLD: assert property (s_high_drive |-> sda_oe_o)
      else $error("data released while clock high");
   AST_START_SEEN: assert property (s_start |-> ##[1:6] start_o)
      else $error("start not reported");
   AST_STOP_IDLE: assert property (s_stop |-> ##[1:6] stop_o ##[0:4] !busy_o)
      else $error("stop not reported or still busy");
   AST_ALERT_COMP: assert property ((alert_mode_i == TWTB_ALERT_COMP &&
      $stable(alert_req_i))[*3] |-> alert_oe_o == alert_req_i)
      else $error("comparator alert does not follow request");
   AST_RX_HOLD: assert property (rx_valid_o && !rx_ready_i |=>
      rx_valid_o && $stable(rx_data_o))
      else $error("received byte dropped while stalled");
endmodule

bind twtb_target twtb_target_asserts u_chk (
   .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_req_i(alert_req_i),
   .alert_mode_i(alert_mode_i), .alert_oe_o(alert_oe_o),
   .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
   .busy_o(busy_o), .bus_idle_o(bus_idle_o), .start_o(start_o),
   .stop_o(stop_o)
);

// File: tb/twtb_master.sv
`timescale 1ns/1ps
module twtb_master (
   output logic scl_o,
   output logic pull_o,
   input wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   task automatic drop;
      #60 scl_o = 1'b0;
   endtask
   // Commands open with a Start, except the one that t_ignore sends.
   task automatic start;
      #100 pull_o = 1'b0;
      #40 scl_o = 1'b1;
      #60 pull_o = 1'b1;
      #60 scl_o = 1'b0;
   endtask
   task automatic stop;
      #100 pull_o = 1'b1;
      #40 scl_o = 1'b1;
      #60 pull_o = 1'b0;
      #60;
   endtask
   task automatic bit_x(input logic b, output logic r);
      #10 pull_o = !b; // Data moves only while the clock is low.
      #120 scl_o = 1'b1;
      #15 r = sda_i;
      #15 scl_o = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a_in,
      output logic [7:0] q, output logic a_out);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]); // Top bit first, no gaps.
      end
      bit_x(a_in, a_out); // Ninth clock, line free when a_in is high.
   endtask
endmodule

// File: tb/tb_twtb_target.sv
`timescale 1ns/1ps
module tb_twtb_target;
   import twtb_pkg::*;
   localparam logic [2:0] STRAP = 3'h_5;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic scl, pull, oe, alert_oe, tx_ready, rx_first, rx_valid, ack;
   logic sel_read, busy, idle, st;
   logic alert_req = 1'b0;
   logic alert_crit = 1'b0;
   logic alert_clear = 1'b0;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic [1:0] alert_mode = 2'h_3;
   logic [7:0] tx_data = 8'h_00;
   logic [7:0] rx_data, q;
   logic [3:0] sel_type;
   int err_total = 0;
   int num_checks = 0;
   int n_start = 0;
   wire logic sda = !(pull || oe);
   twtb_target #(.FIFO_DEPTH(TWTB_FIFO_DEPTH)) DUT (
      .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(), .sda_oe_o(oe), .addr_strap_bit2_i(STRAP[2]),
      .addr_strap_bit1_i(STRAP[1]), .addr_strap_bit0_i(STRAP[0]),
      .alert_req_i(alert_req), .alert_crit_i(alert_crit),
      .alert_mode_i(alert_mode), .alert_clear_i(alert_clear), .alert_o(),
      .alert_oe_o(alert_oe), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_first_o(rx_first),
      .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .sel_type_o(sel_type),
      .sel_read_o(sel_read), .busy_o(busy), .bus_idle_o(idle),
      .start_o(st), .stop_o());
   twtb_master mst (.scl_o(scl), .pull_o(pull), .sda_i(sda));
   initial begin
      forever #10 clock_i = !clock_i;
   end
   // The read source offers one byte only; later reads see the default.
   always @(posedge clock_i) begin
      if (tx_ready === 1'b1) tx_valid <= #1 1'b0;
      if (st === 1'b1) n_start++;
   end
   task automatic step;
      @(posedge clock_i);
      #1;
   endtask
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] adr(input logic [3:0] t, input logic rw);
      return {t, STRAP, rw};
   endfunction
   task automatic t_reset;
      step;
      check("idle", idle, 1'b1);
      check("oe", oe, 1'b0);
   endtask
   task automatic t_alert;
      alert_mode = TWTB_ALERT_COMP;
      alert_req = 1'b1;
      repeat (5) step;
      check("alert on", alert_oe, 1'b1);
      alert_req = 1'b0;
      repeat (5) step;
      check("alert off", alert_oe, 1'b0);
      alert_mode = TWTB_ALERT_INTR;
      alert_req = 1'b1;
      step;
      alert_req = 1'b0;
      repeat (4) step;
      check("alert sticky", alert_oe, 1'b1);
      alert_clear = 1'b1;
      step;
      alert_clear = 1'b0;
      repeat (4) step;
      check("alert cleared", alert_oe, 1'b0);
      alert_mode = TWTB_ALERT_CRIT;
      alert_crit = 1'b1;
      repeat (4) step;
      check("alert crit", alert_oe, 1'b1);
      alert_crit = 1'b0;
      alert_mode = 2'h_3;
      repeat (4) step;
      check("alert none", alert_oe, 1'b0);
   endtask
   task automatic t_ignore;
      mst.drop;
      mst.xfer(adr(TWTB_TYPE_MEM, 1'b0), 1'b1, q, ack);
      check("ack no start", ack, 1'b1);
      check("busy no start", busy, 1'b0);
   endtask
   task automatic t_types;
      logic [3:0] t[3];
      t = '{TWTB_TYPE_MEM, TWTB_TYPE_PAGE, TWTB_TYPE_TEMP};
      foreach (t[i]) begin
         mst.start;
         mst.xfer(adr(t[i], 1'b0), 1'b1, q, ack);
         check("addr ack", ack, 1'b0);
         check("type", sel_type, t[i]);
         mst.stop;
         repeat (8) step;
         check("idle", idle, 1'b1);
      end
      mst.start;
      mst.xfer({TWTB_TYPE_MEM, ~STRAP, 1'b0}, 1'b1, q, ack);
      check("bad addr ack", ack, 1'b1);
      check("standby", busy, 1'b0);
      mst.stop;
   endtask
   task automatic t_fill;
      mst.start;
      mst.xfer(adr(TWTB_TYPE_MEM, 1'b0), 1'b1, q, ack);
      // Output register plus eight queue words hold nine; the tenth is refused.
      for (int i = 0; i < 10; i++) begin
         mst.xfer(8'(8'h_35 + i * 8'h_1d), 1'b1, q, ack);
         check("fill ack", ack, i == 9);
      end
      mst.stop;
      for (int i = 0; i < 9; i++) begin
         for (int k = 0; k < 50 && rx_valid !== 1'b1; k++) step;
         check("rx data", rx_data, 8'(8'h_35 + i * 8'h_1d));
         check("rx first", rx_first, i == 0);
         rx_ready = 1'b1;
         step;
         rx_ready = 1'b0;
      end
      step;
      check("drained", rx_valid, 1'b0);
   endtask
   task automatic t_read;
      int s0;
      step;
      s0 = n_start;
      tx_data = 8'h_c5;
      tx_valid = 1'b1;
      mst.start;
      mst.xfer(adr(TWTB_TYPE_TEMP, 1'b0), 1'b1, q, ack);
      mst.start;
      mst.xfer(adr(TWTB_TYPE_TEMP, 1'b1), 1'b1, q, ack);
      check("rd addr ack", ack, 1'b0);
      check("rd sel", sel_read, 1'b1);
      mst.xfer(8'h_ff, 1'b0, q, ack);
      check("rd byte", q, 8'h_c5);
      mst.xfer(8'h_ff, 1'b1, q, ack);
      check("rd empty", q, TWTB_TX_RESET);
      check("released", oe, 1'b0);
      mst.stop;
      check("starts", 8'(n_start - s0), 8'h_02);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      #1 rst_i = 1'b0;
      repeat (4) step;
      t_reset;
      t_alert;
      t_ignore;
      t_types;
      t_fill;
      t_read;
      tally_and_finish;
   end
   initial begin
      #1_000_000;
      err_total++;
      tally_and_finish;
   end
endmodule
